//--- design/bfx_pkg.sv
// constants and types shared by the breaker failure timer files
// Function
// - current mode: current pick-up starts failure timer
// - current mode: expiry with current raises failure
// - current mode: timer clears when currents drop
// - and mode: timer runs only with trip too
// - and mode: either release resets timer
// - or mode: current or trip starts timer
// - or mode: either held through delay fails
// - or mode: reset only when both released
// - input mode: digital input starts, optionally qualified
// - input mode: expiry issues failure command
// - input mode: retrip and failure, own delays
// - separate on and off events per status, except blocked
// - per-event mask selects on, off, both
// - every event carries a time stamp
// - resettable counters for retrip, failure, start, blocked
// - last twelve fault records kept circularly
// - record holds time, event, currents, remainders, group
// - block sampled each cycle; blocked replaces start
// - one pick-up starts both timers
// - failure delay in 5 ms steps, default 200 ms
package bfx_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned TICK_NS = 5000000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int unsigned TICK_W = $clog2(TICK_CYCLES);
  localparam int unsigned STEP_MS = 5;
  localparam int unsigned RETRIP_DLY_MS = 100;
  localparam int unsigned BF_DLY_MS = 200;
  localparam int DLY_W = 20;
  localparam logic [DLY_W-1:0] RETRIP_DLY_RST = DLY_W'(RETRIP_DLY_MS / STEP_MS);
  localparam logic [DLY_W-1:0] BF_DLY_RST = DLY_W'(BF_DLY_MS / STEP_MS);

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RETRIP_DLY = 8'h04;
  localparam logic [7:0] OFS_BF_DLY = 8'h08;
  localparam logic [7:0] OFS_EVT_MASK = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_STAMP = 8'h14;
  localparam logic [7:0] OFS_CNT_RETRIP = 8'h18;
  localparam logic [7:0] OFS_CNT_BF = 8'h1C;
  localparam logic [7:0] OFS_CNT_START = 8'h20;
  localparam logic [7:0] OFS_CNT_BLOCKED = 8'h24;
  localparam logic [7:0] OFS_CNT_CLR = 8'h28;
  localparam logic [7:0] OFS_REC_SEL = 8'h2C;
  localparam logic [7:0] OFS_REC_TIME = 8'h30;
  localparam logic [7:0] OFS_REC_INFO = 8'h34;
  localparam logic [7:0] OFS_REC_CUR = 8'h38;
  localparam logic [7:0] OFS_REC_RRT = 8'h3C;
  localparam logic [7:0] OFS_REC_RBF = 8'h40;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CRIT_LSB = 0;
  localparam int CTRL_RETRIP_EN = 2;
  localparam int CTRL_QUAL_CUR = 3;
  localparam int CTRL_QUAL_DO = 4;
  localparam logic [4:0] CTRL_RST = 5'h04;
  localparam logic [15:0] EVT_MASK_RST = 16'hFFFF;
  localparam int STAT_WP_LSB = 16;
  localparam int STAT_CNT_LSB = 20;
  localparam int INFO_GRP_LSB = 8;

  // status bit positions; the low eight produce events
  localparam int ST_START = 0;
  localparam int ST_RETRIP = 1;
  localparam int ST_BF = 2;
  localparam int ST_BLOCK = 3;
  localparam int ST_DOMON = 4;
  localparam int ST_SIGNAL = 5;
  localparam int ST_PHASE = 6;
  localparam int ST_RES = 7;
  localparam int ST_BLOCKED = 8;
  localparam int N_EVT = 8;
  localparam int N_CNT = 4;
  localparam int REC_DEPTH = 12;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // start criterion selection
  typedef enum logic [1:0] {
    CRIT_CUR,
    CRIT_CUR_AND_DO,
    CRIT_CUR_OR_DO,
    CRIT_DIG_IN
  } bfx_crit_t;

endpackage : bfx_pkg

//--- design/bfx_delay_timer.sv
// delay timer counting program-cycle ticks up to a set delay
module bfx_delay_timer (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic tick, // program cycle enable pulse
  input wire logic run, // count on this tick
  input wire logic clear, // return to zero on this tick
  input wire logic [bfx_pkg::DLY_W-1:0] delay, // delay in ticks
  output logic done, // delay reached
  output logic [bfx_pkg::DLY_W-1:0] remain // ticks left
);

  logic [bfx_pkg::DLY_W-1:0] cnt_r;
  logic done_r;
  logic [bfx_pkg::DLY_W-1:0] cnt_nxt;

  // elapsed count after this tick
  assign cnt_nxt = cnt_r + bfx_pkg::DLY_W'(1);
  assign done = done_r;
  assign remain = done_r ? '0 : (delay > cnt_r) ? delay - cnt_r : '0;

  // count while running; done on the first tick reaching delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (tick) begin
      if (clear) begin
        cnt_r <= '0;
        done_r <= 1'b0;
      end else if (run && !done_r) begin
        cnt_r <= cnt_nxt;
        done_r <= (cnt_nxt >= delay);
      end
    end
  end

endmodule : bfx_delay_timer

//--- design/bfx_breaker_failure_timer.sv
// breaker failure supervision: criteria, timers, events, counters, records
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
module bfx_breaker_failure_timer #(
  parameter int unsigned TICK_CYC = bfx_pkg::TICK_CYCLES // program cycle
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic phase_pickup, // phase current above threshold
  input wire logic res_pickup, // residual current above threshold
  input wire logic trip_monitor, // monitored primary trip output
  input wire logic dig_input, // dedicated failure start input
  input wire logic block_in, // block input
  input wire logic [15:0] max_phase_current, // highest phase current
  input wire logic [15:0] res_current, // residual current
  input wire logic [2:0] setting_group, // active setting group
  output logic start_out, // start indication
  output logic retrip_out, // retrip to redundant coil
  output logic breaker_failure_output, // trip to incoming breaker
  output logic blocked_out, // blocked indication
  output logic evt_valid, // event edges present, one cycle
  output logic [7:0] evt_on, // masked on edges
  output logic [7:0] evt_off, // masked off edges
  output logic [31:0] evt_stamp // time stamp of the event edges
);

  localparam int DW = bfx_pkg::DLY_W;
  localparam int TW = bfx_pkg::TICK_W;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // merge write data into a word under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // lowest set bit index of an event vector
  function automatic logic [3:0] first_set(input logic [7:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = bfx_pkg::N_EVT - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_set

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [4:0] pin_m_r;
  logic [4:0] pin_s_r;
  logic [TW-1:0] div_r;
  logic tick_r;
  logic tick_d_r;
  logic [31:0] stamp_r;
  logic [4:0] ctrl_r;
  logic [DW-1:0] rdly_r;
  logic [DW-1:0] bdly_r;
  logic [15:0] mask_r;
  logic [3:0] rsel_r;
  logic [8:0] status_r;
  logic [8:0] status_nxt;
  logic [7:0] snap_r;
  logic start_snap_r;
  logic blocked_snap_r;
  logic [15:0] cnt_r [bfx_pkg::N_CNT];
  logic [3:0] wp_r;
  logic [3:0] nrec_r;
  logic [31:0] rec_time [bfx_pkg::REC_DEPTH];
  logic [31:0] rec_info [bfx_pkg::REC_DEPTH];
  logic [31:0] rec_cur [bfx_pkg::REC_DEPTH];
  logic [DW-1:0] rec_rrt [bfx_pkg::REC_DEPTH];
  logic [DW-1:0] rec_rbf [bfx_pkg::REC_DEPTH];
  logic evt_valid_r;
  logic [7:0] evt_on_r;
  logic [7:0] evt_off_r;
  logic [31:0] evt_stamp_r;
  logic awready_r;
  logic wready_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic pick;
  logic run_c;
  logic [31:0] rd_word;
  logic rd_ok;

  // ----------------------------------------------------------------
  // pin synchronisers and program cycle divider
  // ----------------------------------------------------------------
  wire blk_s = pin_s_r[0];
  wire trip_s = pin_s_r[1];
  wire di_s = pin_s_r[2];
  wire ph_s = pin_s_r[3];
  wire res_s = pin_s_r[4];
  wire tick_now = (div_r == TW'(TICK_CYC - 1));

  // two flip-flops per pin, then a tick counter and time base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_r <= 5'h00;
      pin_s_r <= 5'h00;
      div_r <= '0;
      tick_r <= 1'b0;
      tick_d_r <= 1'b0;
      stamp_r <= 32'h0;
    end else begin
      pin_m_r <= {res_pickup, phase_pickup, dig_input, trip_monitor, block_in};
      pin_s_r <= pin_m_r;
      div_r <= tick_now ? '0 : div_r + TW'(1);
      tick_r <= tick_now;
      tick_d_r <= tick_r;
      if (tick_r) begin
        stamp_r <= stamp_r + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // start criteria
  // ----------------------------------------------------------------
  wire cur = ph_s | res_s;
  wire qual_cur = ctrl_r[bfx_pkg::CTRL_QUAL_CUR];
  wire qual_do = ctrl_r[bfx_pkg::CTRL_QUAL_DO];
  wire retrip_en = ctrl_r[bfx_pkg::CTRL_RETRIP_EN];
  wire [1:0] crit_raw = ctrl_r[bfx_pkg::CTRL_CRIT_LSB +: 2];
  wire bfx_pkg::bfx_crit_t crit = bfx_pkg::bfx_crit_t'(crit_raw);

  // pick-up and timer run condition for the selected criterion
  always_comb begin
    pick = 1'b0;
    run_c = 1'b0;
    unique case (crit)
      bfx_pkg::CRIT_CUR: begin
        pick = cur;
        run_c = cur;
      end
      bfx_pkg::CRIT_CUR_AND_DO: begin
        pick = cur;
        run_c = cur & trip_s;
      end
      bfx_pkg::CRIT_CUR_OR_DO: begin
        pick = cur | trip_s;
        run_c = cur | trip_s;
      end
      bfx_pkg::CRIT_DIG_IN: begin
        pick = di_s & (!qual_cur | cur) & (!qual_do | trip_s);
        run_c = pick;
      end
    endcase
  end

  // block sampled at the program cycle tick gates start
  wire start_now = pick & !blk_s;
  wire blocked_now = pick & blk_s;
  wire tmr_run = start_now & run_c;
  wire tmr_clr = !tmr_run;

  // ----------------------------------------------------------------
  // retrip and failure timers from the same pick-up
  // ----------------------------------------------------------------
  logic rt_done;
  logic bf_done;
  logic [DW-1:0] rt_rem;
  logic [DW-1:0] bf_rem;

  bfx_delay_timer u_retrip (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_r),
    .run(tmr_run & retrip_en),
    .clear(tmr_clr | !retrip_en),
    .delay(rdly_r),
    .done(rt_done),
    .remain(rt_rem)
  );

  bfx_delay_timer u_failure (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_r),
    .run(tmr_run),
    .clear(tmr_clr),
    .delay(bdly_r),
    .done(bf_done),
    .remain(bf_rem)
  );

  // ----------------------------------------------------------------
  // status, events and counters
  // ----------------------------------------------------------------
  // inputs and start state frozen at the tick, timers read one later
  always_comb begin
    status_nxt = 9'h000;
    status_nxt[bfx_pkg::ST_START] = start_snap_r;
    status_nxt[bfx_pkg::ST_RETRIP] = rt_done;
    status_nxt[bfx_pkg::ST_BF] = bf_done;
    status_nxt[bfx_pkg::ST_BLOCK] = snap_r[0];
    status_nxt[bfx_pkg::ST_DOMON] = snap_r[1];
    status_nxt[bfx_pkg::ST_SIGNAL] = snap_r[2];
    status_nxt[bfx_pkg::ST_PHASE] = snap_r[3];
    status_nxt[bfx_pkg::ST_RES] = snap_r[4];
    status_nxt[bfx_pkg::ST_BLOCKED] = blocked_snap_r;
  end

  wire [8:0] rise = status_nxt & ~status_r;
  wire [8:0] fall = status_r & ~status_nxt;
  logic [7:0] mask_on;
  logic [7:0] mask_off;

  // even mask bits enable on edges, odd bits off edges
  always_comb begin
    for (int i = 0; i < bfx_pkg::N_EVT; i++) begin
      mask_on[i] = mask_r[2*i];
      mask_off[i] = mask_r[2*i+1];
    end
  end

  wire [7:0] on_m = rise[7:0] & mask_on;
  wire [7:0] off_m = fall[7:0] & mask_off;
  wire [3:0] cnt_inc = {rise[bfx_pkg::ST_BLOCKED], rise[bfx_pkg::ST_START],
                        rise[bfx_pkg::ST_BF], rise[bfx_pkg::ST_RETRIP]};
  wire rec_we = tick_d_r && (rise[7:0] != 8'h00);
  wire w_do = aw_got_r & w_got_r & !bvalid_r;
  wire [31:0] w_cur_clr = merge(32'h0, w_data_r, w_strb_r);
  wire [3:0] cnt_clr = (w_do && aw_addr_r == bfx_pkg::OFS_CNT_CLR) ?
                       w_cur_clr[3:0] : 4'h0;

  // snapshot, status and event output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_r <= 8'h00;
      start_snap_r <= 1'b0;
      blocked_snap_r <= 1'b0;
      status_r <= 9'h000;
      evt_valid_r <= 1'b0;
      evt_on_r <= 8'h00;
      evt_off_r <= 8'h00;
      evt_stamp_r <= 32'h0;
    end else begin
      if (tick_r) begin
        snap_r <= {3'h0, pin_s_r};
        start_snap_r <= start_now;
        blocked_snap_r <= blocked_now;
      end
      evt_valid_r <= tick_d_r && ((on_m | off_m) != 8'h00);
      if (tick_d_r) begin
        status_r <= status_nxt;
        evt_on_r <= on_m;
        evt_off_r <= off_m;
        evt_stamp_r <= stamp_r;
      end
    end
  end

  // counters: a same-cycle clear and increment leaves a count of one
  always_ff @(posedge aclk) begin
    for (int i = 0; i < bfx_pkg::N_CNT; i++) begin
      if (!aresetn) begin
        cnt_r[i] <= 16'h0000;
      end else begin
        cnt_r[i] <= (cnt_clr[i] ? 16'h0000 : cnt_r[i])
                    + 16'(tick_d_r & cnt_inc[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // fault record store
  // ----------------------------------------------------------------
  // write pointer wraps over the twelve slots
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= 4'h0;
      nrec_r <= 4'h0;
    end else if (rec_we) begin
      wp_r <= (wp_r == 4'(bfx_pkg::REC_DEPTH - 1)) ? 4'h0 : wp_r + 4'h1;
      if (nrec_r != 4'(bfx_pkg::REC_DEPTH)) begin
        nrec_r <= nrec_r + 4'h1;
      end
    end
  end

  // record contents taken on an on edge
  always_ff @(posedge aclk) begin
    if (rec_we) begin
      rec_time[wp_r] <= stamp_r;
      rec_info[wp_r] <= {21'h0, setting_group, 4'h0, first_set(rise[7:0])};
      rec_cur[wp_r] <= {max_phase_current, res_current};
      rec_rrt[wp_r] <= rt_rem;
      rec_rbf[wp_r] <= bf_rem;
    end
  end

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  wire aw_hs = awvalid & awready_r;
  wire w_hs = wvalid & wready_r;
  wire ar_hs = arvalid & arready_r;
  wire rsel_ok = (rsel_r < 4'(bfx_pkg::REC_DEPTH));
  wire [3:0] rs = rsel_ok ? rsel_r : 4'h0;
  wire [31:0] w_ctrl = merge({27'h0, ctrl_r}, w_data_r, w_strb_r);
  wire [31:0] w_rdly = merge(32'(rdly_r), w_data_r, w_strb_r);
  wire [31:0] w_bdly = merge(32'(bdly_r), w_data_r, w_strb_r);
  wire [31:0] w_mask = merge({16'h0, mask_r}, w_data_r, w_strb_r);
  wire [31:0] w_rsel = merge({28'h0, rsel_r}, w_data_r, w_strb_r);
  wire [7:0] wa = aw_addr_r;
  wire w_map = wa inside {bfx_pkg::OFS_CTRL, bfx_pkg::OFS_RETRIP_DLY,
                          bfx_pkg::OFS_BF_DLY, bfx_pkg::OFS_EVT_MASK,
                          bfx_pkg::OFS_CNT_CLR, bfx_pkg::OFS_REC_SEL};

  // read data selection
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    unique case (araddr)
      bfx_pkg::OFS_CTRL: rd_word = {27'h0, ctrl_r};
      bfx_pkg::OFS_RETRIP_DLY: rd_word = 32'(rdly_r);
      bfx_pkg::OFS_BF_DLY: rd_word = 32'(bdly_r);
      bfx_pkg::OFS_EVT_MASK: rd_word = {16'h0, mask_r};
      bfx_pkg::OFS_STATUS: rd_word = {8'h0, nrec_r, wp_r, 7'h0, status_r};
      bfx_pkg::OFS_STAMP: rd_word = stamp_r;
      bfx_pkg::OFS_CNT_RETRIP: rd_word = {16'h0, cnt_r[0]};
      bfx_pkg::OFS_CNT_BF: rd_word = {16'h0, cnt_r[1]};
      bfx_pkg::OFS_CNT_START: rd_word = {16'h0, cnt_r[2]};
      bfx_pkg::OFS_CNT_BLOCKED: rd_word = {16'h0, cnt_r[3]};
      bfx_pkg::OFS_CNT_CLR: rd_word = 32'h0;
      bfx_pkg::OFS_REC_SEL: rd_word = {28'h0, rsel_r};
      bfx_pkg::OFS_REC_TIME: rd_word = rsel_ok ? rec_time[rs] : 32'h0;
      bfx_pkg::OFS_REC_INFO: rd_word = rsel_ok ? rec_info[rs] : 32'h0;
      bfx_pkg::OFS_REC_CUR: rd_word = rsel_ok ? rec_cur[rs] : 32'h0;
      bfx_pkg::OFS_REC_RRT: rd_word = rsel_ok ? 32'(rec_rrt[rs]) : 32'h0;
      bfx_pkg::OFS_REC_RBF: rd_word = rsel_ok ? 32'(rec_rbf[rs]) : 32'h0;
      default: rd_ok = 1'b0;
    endcase
  end

  // write channels taken in either order, one response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= bfx_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awready_r <= 1'b0;
        aw_got_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (w_hs) begin
        wready_r <= 1'b0;
        w_got_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (w_do) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= w_map ? bfx_pkg::RESP_OKAY : bfx_pkg::RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= bfx_pkg::CTRL_RST;
      rdly_r <= bfx_pkg::RETRIP_DLY_RST;
      bdly_r <= bfx_pkg::BF_DLY_RST;
      mask_r <= bfx_pkg::EVT_MASK_RST;
      rsel_r <= 4'h0;
    end else if (w_do) begin
      if (wa == bfx_pkg::OFS_CTRL) ctrl_r <= w_ctrl[4:0];
      if (wa == bfx_pkg::OFS_RETRIP_DLY) rdly_r <= w_rdly[DW-1:0];
      if (wa == bfx_pkg::OFS_BF_DLY) bdly_r <= w_bdly[DW-1:0];
      if (wa == bfx_pkg::OFS_EVT_MASK) mask_r <= w_mask[15:0];
      if (wa == bfx_pkg::OFS_REC_SEL) rsel_r <= w_rsel[3:0];
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= bfx_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_ok ? bfx_pkg::RESP_OKAY : bfx_pkg::RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign start_out = status_r[bfx_pkg::ST_START];
  assign retrip_out = status_r[bfx_pkg::ST_RETRIP];
  assign breaker_failure_output = status_r[bfx_pkg::ST_BF];
  assign blocked_out = status_r[bfx_pkg::ST_BLOCKED];
  assign evt_valid = evt_valid_r;
  assign evt_on = evt_on_r;
  assign evt_off = evt_off_r;
  assign evt_stamp = evt_stamp_r;

endmodule : bfx_breaker_failure_timer

//--- dv/bfx_monitor.sv
// checker on the breaker failure timer ports
module bfx_monitor #(
  parameter int unsigned TICK_CYC = 8 // program cycle
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic awvalid, // in
  input wire logic awready, // out
  input wire logic wvalid, // in
  input wire logic wready, // out
  input wire logic [1:0] bresp, // out
  input wire logic bvalid, // out
  input wire logic bready, // in
  input wire logic arvalid, // in
  input wire logic arready, // out
  input wire logic rvalid, // out
  input wire logic start_out, // out
  input wire logic retrip_out, // out
  input wire logic breaker_failure_output, // out
  input wire logic blocked_out, // out
  input wire logic evt_valid, // out
  input wire logic [7:0] evt_on, // out
  input wire logic [7:0] evt_off // out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // bus answers and their holding; a write answers two edges after both
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("late read answer");
  a_wr_answer: assert property (awvalid && awready && wvalid && wready
    |=> ##1 bvalid) else $error("late write answer");
  // outputs against the pick-up state
  a_fail_start: assert property (
    breaker_failure_output |-> start_out) else $error("failure unstarted");
  a_retrip_start: assert property (
    retrip_out |-> start_out) else $error("retrip unstarted");
  a_start_blocked: assert property (
    !(start_out && blocked_out)) else $error("start while blocked");
  a_evt_pulse: assert property (
    evt_valid |=> !evt_valid) else $error("event pulse too long");
  a_evt_start_on: assert property (
    evt_valid && evt_on[0] |-> start_out) else $error("bad start event");
  a_evt_fail_off: assert property (
    evt_valid && evt_off[2] |-> !breaker_failure_output)
    else $error("bad failure event");
  c_fail: cover property ($rose(breaker_failure_output));
  c_retrip: cover property ($rose(retrip_out));
  c_block: cover property (blocked_out);
endmodule : bfx_monitor

//--- dv/bfx_partner.sv
// primary trip stage and breaker coils beside the timer
module bfx_partner (
  input wire logic aclk, // clock
  input wire logic trip_cmd, // primary stage operates
  input wire logic breaker_failure_output, // incoming breaker coil
  output logic trip_monitor, // monitored trip contact
  output logic upstream_open // incoming breaker opened
);
  // contact follows the stage a cycle later, breaker follows its coil
  always_ff @(posedge aclk) begin
    trip_monitor <= trip_cmd;
    upstream_open <= breaker_failure_output;
  end
endmodule : bfx_partner

//--- dv/tb_breaker_failure_timer.sv
// testbench of the breaker failure timer
module tb_breaker_failure_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = '0, aresetn = '0, bready = '1, rready = '1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, stamp, d;
  logic awvalid = '0, wvalid = '0, arvalid = '0;
  logic awready, wready, bvalid, arready, rvalid, trip_mon, up_open;
  logic [1:0] bresp, rresp, r;
  logic phase = '0, res = '0, trip_cmd = '0, dig = '0, blk = '0;
  logic start_out, retrip_out, breaker_failure_output, blocked_out;
  logic evt_valid;
  logic [7:0] evt_on, evt_off;
  logic [5:0] cs [6] = '{6'h24, 6'h05, 6'h2D, 6'h2A, 6'h33, 6'h08};
  int failures = 0, total_checks = 0;
  bfx_breaker_failure_timer #(.TICK_CYC(8)) DUT (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .phase_pickup(phase), .res_pickup(res),
    .trip_monitor(trip_mon), .dig_input(dig), .block_in(blk),
    .max_phase_current(16'h0123), .res_current(16'h0045),
    .setting_group(3'h1), .start_out, .retrip_out, .breaker_failure_output,
    .blocked_out, .evt_valid, .evt_on, .evt_off, .evt_stamp(stamp));
  bfx_partner u_partner (.aclk, .trip_cmd, .breaker_failure_output,
    .trip_monitor(trip_mon), .upstream_open(up_open));
  initial forever #5 aclk = ~aclk;
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_end(input int n);
    if (n != 99) begin
      failures++;
      $display("Error %0t: bus wait ran out", $time);
      summarize();
    end
  endtask : bus_end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) n = 99;
    end
    bus_end(n);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        n = 99;
      end
    end
    bus_end(n);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rc
  // reset values, refused access, then criteria, block and counters
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rc(bfx_pkg::OFS_CTRL, 32'h4);
    rc(bfx_pkg::OFS_BF_DLY, 32'h28);
    rd(8'h80);
    chk({30'h0, r}, {30'h0, bfx_pkg::RESP_SLVERR});
    wr(bfx_pkg::OFS_RETRIP_DLY, 32'h2);
    wr(bfx_pkg::OFS_BF_DLY, 32'h3);
    foreach (cs[i]) begin
      wr(bfx_pkg::OFS_CTRL, {30'h1, cs[i][1:0]});
      {dig, trip_cmd, phase} <= cs[i][4:2];
      repeat (40) @(posedge aclk);
      chk({31'h0, breaker_failure_output}, {31'h0, cs[i][5]});
      {dig, trip_cmd, phase} <= 3'h0;
      repeat (40) @(posedge aclk);
      chk({31'h0, breaker_failure_output}, 32'h0);
      $display("criterion case %0d done", i);
    end
    wr(bfx_pkg::OFS_CTRL, 32'h6);
    {res, trip_cmd} <= 2'h3;
    repeat (40) @(posedge aclk);
    res <= 1'h0;
    repeat (16) @(posedge aclk);
    chk({30'h0, up_open, breaker_failure_output}, 32'h3);
    trip_cmd <= 1'h0;
    repeat (40) @(posedge aclk);
    chk({31'h0, breaker_failure_output}, 32'h0);
    $display("or case done");
    wr(bfx_pkg::OFS_CTRL, 32'h4);
    {blk, phase} <= 2'h3;
    repeat (40) @(posedge aclk);
    chk({29'h0, start_out, blocked_out, retrip_out}, 32'h2);
    {blk, phase} <= 2'h0;
    repeat (40) @(posedge aclk);
    $display("block case done");
    rc(bfx_pkg::OFS_CNT_BF, 32'h5);
    rc(bfx_pkg::OFS_CNT_RETRIP, 32'h5);
    rc(bfx_pkg::OFS_CNT_BLOCKED, 32'h1);
    rd(bfx_pkg::OFS_STATUS);
    chk({28'h0, d[23:20]}, 32'hC);
    wr(bfx_pkg::OFS_CNT_CLR, 32'hF);
    rc(bfx_pkg::OFS_CNT_BF, 32'h0);
    $display("counter case done");
    summarize();
  end
endmodule : tb_breaker_failure_timer
bind bfx_breaker_failure_timer bfx_monitor #(.TICK_CYC(TICK_CYC)) u_mon (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rvalid, .start_out, .retrip_out,
  .breaker_failure_output, .blocked_out, .evt_valid, .evt_on, .evt_off);
